// File: boundary_scan_tap_pkg.sv
/*
 * Shared constants and types for the boundary-scan test access port:
 * instruction codes, identification fields, chain layout, bus offsets.
 * Assumes a single 40 MHz system clock samples every test pin.
 */
package boundary_scan_tap_pkg;

    // ------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------
    localparam int IR_W = 5;
    localparam logic [IR_W-1:0] INSTR_EXTEST = 5'h00;
    localparam logic [IR_W-1:0] INSTR_SAMPLE = 5'h01;
    localparam logic [IR_W-1:0] INSTR_INT_SCAN = 5'h02;
    localparam logic [IR_W-1:0] INSTR_CLAMP = 5'h04;
    localparam logic [IR_W-1:0] INSTR_HIGHZ = 5'h05;
    localparam logic [IR_W-1:0] INSTR_MEM_SELFTEST = 5'h0A;
    localparam logic [IR_W-1:0] INSTR_IDCODE = 5'h0C;
    localparam logic [IR_W-1:0] INSTR_BYPASS = 5'h1F;
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 5'h01;

    // ------------------------------------------------------------
    // identification word (values arbitrary)
    // ------------------------------------------------------------
    localparam logic [3:0] ID_VERSION = 4'h0;
    localparam logic [15:0] ID_PART = 16'h0000;
    localparam logic [10:0] ID_MAKER = 11'h000;
    localparam logic ID_FIXED_BIT = 1'b1;

    // ------------------------------------------------------------
    // chain layout: each pin has a data cell then a control cell
    // ------------------------------------------------------------
    localparam int NPIN = 22;
    localparam int BSR_LEN = 2 * NPIN;
    localparam int LOCK_CELL = 42;

    // ------------------------------------------------------------
    // register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IDCODE = 8'h08;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [1:0] {PATH_BSR, PATH_BYP, PATH_ID, PATH_INT} path_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tap_pins_t;

    typedef struct packed {
        logic [NPIN-1:0] dout;
        logic [NPIN-1:0] oe;
    } pin_drive_t;

endpackage

// File: boundary_scan_tap.sv
/*
 * Boundary-scan test access port with a 16-state controller, 5-bit
 * instruction register, bypass, identification and boundary registers,
 * plus an AHB-Lite slave for control and status.
 * Assumes test pins and pad inputs are asynchronous to clk_in and that
 * test clock phases last at least three system clocks.
 */
// Chosen here: the AHB-Lite register port and the register addresses.
// How it works
// RQ1: every system pin sits in the chain
// RQ2: sixteen-state controller stepped by tck, tms
// RQ3: power-on reset forces Test-Logic-Reset
// RQ4: test lines ignored during bus cycles; trst_n still forces Test-Logic-Reset
// RQ5: five-bit instruction picks the data path
// RQ6: unassigned codes act as bypass
// RQ7: EXTEST drives pins from chain cells
// RQ8: SAMPLE captures pins, normal pin operation
// RQ9: HIGHZ floats all pins, selects bypass
// RQ10: CLAMP drives pins from cells, bypass path
// RQ11: IDCODE selects 32-bit identification word
// RQ12: internal scan and memory self-test paths
// RQ13: bypass is one shift stage
// RQ14: bypass selectable when not testing
// RQ15: id holds version, part, maker fields
// RQ16: id bit zero is constant one
// RQ17: chain shifts from tdi to tdo
// RQ18: bidirectional data and control cell types
// RQ19: cells capture on rising tck edge
// RQ20: cell zero is bit zero, lock cell 42
// RQ21: standard state diagram, update loads instruction
// RQ22: tdo on falling edge, driven only shifting
`timescale 1ns/1ps
module boundary_scan_tap
    import boundary_scan_tap_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    // test pins
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    input wire logic trst_n_in,
    output logic tdo_out,
    output logic tdo_oe_out,
    // parallel bus activity from system logic
    input wire logic bus_active_in,
    // system side of the pads
    input wire logic [NPIN-1:0] core_dout_in,
    input wire logic [NPIN-1:0] core_oe_in,
    input wire logic [NPIN-1:0] pad_in,
    output logic [NPIN-1:0] pad_dout_out,
    output logic [NPIN-1:0] pad_oe_out,
    // internal test paths
    input wire logic int_scan_tdo_in,
    input wire logic mem_selftest_tdo_in,
    output logic int_scan_sel_out,
    output logic memory_selftest_instr_out,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        tap_pins_t s1;
        tap_pins_t s2;
        logic tck_prev;
        logic [NPIN-1:0] pad_s1;
        logic [NPIN-1:0] pad_s2;
        tap_state_t tap;
        logic [IR_W-1:0] ir_sh;
        logic [IR_W-1:0] ir;
        logic byp;
        logic [31:0] id_sh;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_upd;
        logic tdo;
        logic tdo_oe;
        logic ctrl_en;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT}; // RQ15 RQ16

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic tap_state_t tap_step(input tap_state_t s, input logic tms); // RQ21
        case (s)
            TLR: tap_step = tms ? TLR : RTI;
            RTI: tap_step = tms ? SEL_DR : RTI;
            SEL_DR: tap_step = tms ? SEL_IR : CAP_DR;
            CAP_DR: tap_step = tms ? EX1_DR : SH_DR;
            SH_DR: tap_step = tms ? EX1_DR : SH_DR;
            EX1_DR: tap_step = tms ? UPD_DR : PAU_DR;
            PAU_DR: tap_step = tms ? EX2_DR : PAU_DR;
            EX2_DR: tap_step = tms ? UPD_DR : SH_DR;
            UPD_DR: tap_step = tms ? SEL_DR : RTI;
            SEL_IR: tap_step = tms ? TLR : CAP_IR;
            CAP_IR: tap_step = tms ? EX1_IR : SH_IR;
            SH_IR: tap_step = tms ? EX1_IR : SH_IR;
            EX1_IR: tap_step = tms ? UPD_IR : PAU_IR;
            PAU_IR: tap_step = tms ? EX2_IR : PAU_IR;
            EX2_IR: tap_step = tms ? UPD_IR : SH_IR;
            UPD_IR: tap_step = tms ? SEL_DR : RTI;
            default: tap_step = TLR;
        endcase
    endfunction

    // decodes the instruction into a data path
    function automatic path_t path_of(input logic [IR_W-1:0] ir); // RQ5
        case (ir)
            INSTR_EXTEST, INSTR_SAMPLE: path_of = PATH_BSR; // RQ7 RQ8
            INSTR_IDCODE: path_of = PATH_ID; // RQ11
            INSTR_INT_SCAN, INSTR_MEM_SELFTEST: path_of = PATH_INT; // RQ12
            default: path_of = PATH_BYP; // RQ6 RQ9 RQ10 RQ14
        endcase
    endfunction

    // ------------------------------------------------------------
    // pad multiplexing
    // ------------------------------------------------------------
    logic drive_from_cells;
    logic float_all;
    pin_drive_t cells;

    assign drive_from_cells = (st_reg.ir == INSTR_EXTEST) || (st_reg.ir == INSTR_CLAMP); // RQ7 RQ10
    assign float_all = (st_reg.ir == INSTR_HIGHZ); // RQ9

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            // data cell at 2i, its control cell at 2i+1
            assign cells.dout[gi] = st_reg.bsr_upd[2*gi]; // RQ18 RQ20
            assign cells.oe[gi] = st_reg.bsr_upd[2*gi+1]; // RQ18
        end
    endgenerate

    always_comb begin
        if (float_all) begin
            pad_dout_out = core_dout_in;
            pad_oe_out = '0;
        end else if (drive_from_cells) begin
            pad_dout_out = cells.dout;
            pad_oe_out = cells.oe;
        end else begin
            pad_dout_out = core_dout_in; // RQ8
            pad_oe_out = core_oe_in;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic tck_rise;
    logic tck_fall;
    logic lines_live;
    path_t path;
    logic [31:0] status_word;

    assign lines_live = st_reg.ctrl_en && !bus_active_in; // RQ4
    assign tck_rise = lines_live && st_reg.s2.tck && !st_reg.tck_prev;
    assign tck_fall = lines_live && !st_reg.s2.tck && st_reg.tck_prev;
    assign path = path_of(st_reg.ir);
    assign status_word = {19'h00000, st_reg.ir, 3'h0, st_reg.tap == TLR, st_reg.tap};

    always_comb begin
        st_next = st_reg;
        st_next.s1 = '{tck: tck_in, tms: tms_in, tdi: tdi_in, trst_n: trst_n_in};
        st_next.s2 = st_reg.s1;
        st_next.tck_prev = st_reg.s2.tck;
        st_next.pad_s1 = pad_in;
        st_next.pad_s2 = st_reg.pad_s1;

        // ---------------- rising test clock ----------------
        if (tck_rise) begin
            st_next.tap = tap_step(st_reg.tap, st_reg.s2.tms); // RQ2
            case (st_reg.tap)
                CAP_IR: st_next.ir_sh = IR_CAPTURE_VAL;
                SH_IR: st_next.ir_sh = {st_reg.s2.tdi, st_reg.ir_sh[IR_W-1:1]};
                CAP_DR: begin
                    st_next.byp = 1'b0;
                    st_next.id_sh = ID_WORD;
                    if (path == PATH_BSR) begin
                        for (int i = 0; i < NPIN; i++) begin
                            st_next.bsr_sh[2*i] = st_reg.pad_s2[i]; // RQ19
                            st_next.bsr_sh[2*i+1] = pad_oe_out[i]; // RQ19
                        end
                    end
                end
                SH_DR: begin
                    st_next.byp = st_reg.s2.tdi; // RQ13
                    st_next.id_sh = {st_reg.s2.tdi, st_reg.id_sh[31:1]};
                    if (path == PATH_BSR) begin
                        st_next.bsr_sh = {st_reg.s2.tdi, st_reg.bsr_sh[BSR_LEN-1:1]}; // RQ17
                    end
                end
                default: begin
                end
            endcase
        end

        // ---------------- falling test clock ----------------
        if (tck_fall) begin
            st_next.tdo_oe = (st_reg.tap == SH_DR) || (st_reg.tap == SH_IR); // RQ22
            if (st_reg.tap == SH_IR) begin
                st_next.tdo = st_reg.ir_sh[0];
            end else if (st_reg.tap == SH_DR) begin
                case (path)
                    PATH_BSR: st_next.tdo = st_reg.bsr_sh[0]; // RQ17 RQ20
                    PATH_ID: st_next.tdo = st_reg.id_sh[0];
                    PATH_INT: st_next.tdo = (st_reg.ir == INSTR_INT_SCAN) ?
                        int_scan_tdo_in : mem_selftest_tdo_in;
                    default: st_next.tdo = st_reg.byp; // RQ13
                endcase
            end
            if (st_reg.tap == UPD_IR) begin
                st_next.ir = st_reg.ir_sh; // RQ21
            end
            if (st_reg.tap == UPD_DR && path == PATH_BSR) begin
                st_next.bsr_upd = st_reg.bsr_sh; // RQ8
            end
            if (st_reg.tap == TLR) begin
                st_next.ir = INSTR_IDCODE;
            end
        end

        // ---------------- test reset pin ----------------
        if (!st_reg.s2.trst_n) begin
            st_next.tap = TLR; // RQ22
            st_next.ir = INSTR_IDCODE;
            st_next.tdo_oe = 1'b0;
        end

        // ---------------- ahb-lite slave ----------------
        if (st_reg.wr_pend && st_reg.wr_addr == OFS_CTRL) begin
            st_next.ctrl_en = hwdata_in[0];
        end
        st_next.wr_pend = 1'b0;
        if (hsel_in && hready_in && htrans_in == HTRANS_NONSEQ) begin
            st_next.wr_pend = hwrite_in;
            st_next.wr_addr = {haddr_in[7:2], 2'b00};
            if (!hwrite_in) begin
                case ({haddr_in[7:2], 2'b00})
                    OFS_CTRL: st_next.rdata = {31'h00000000, st_reg.ctrl_en};
                    OFS_STATUS: st_next.rdata = status_word;
                    OFS_IDCODE: st_next.rdata = ID_WORD;
                    default: st_next.rdata = 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_reg <= '0;
            st_reg.s1 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
            st_reg.s2 <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
            st_reg.tap <= TLR; // RQ3
            st_reg.ir <= INSTR_IDCODE;
            st_reg.ctrl_en <= CTRL_EN_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign tdo_out = st_reg.tdo;
    assign tdo_oe_out = st_reg.tdo_oe;
    assign int_scan_sel_out = (st_reg.ir == INSTR_INT_SCAN); // RQ12
    assign memory_selftest_instr_out = (st_reg.ir == INSTR_MEM_SELFTEST); // RQ12
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign hrdata_out = st_reg.rdata;

endmodule // boundary_scan_tap

// File: boundary_scan_tap_chk.sv
/* port checker of the test access port, bound into boundary_scan_tap.
   assumes tck phases last at least four clk_in cycles. */
`timescale 1ns/1ps
module boundary_scan_tap_chk
    import boundary_scan_tap_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tck_in,
    input wire logic trst_n_in,
    input wire logic bus_active_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [NPIN-1:0] core_dout_in,
    input wire logic [NPIN-1:0] core_oe_in,
    input wire logic tdo_out,
    input wire logic tdo_oe_out,
    input wire logic [NPIN-1:0] pad_dout_out,
    input wire logic [NPIN-1:0] pad_oe_out,
    input wire logic int_scan_sel_out,
    input wire logic memory_selftest_instr_out,
    input wire logic [31:0] hrdata_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence id_req;
        hsel_in && hready_in && htrans_in == HTRANS_NONSEQ && !hwrite_in
            && haddr_in == 32'(OFS_IDCODE);
    endsequence
    sequence bus_busy;
        bus_active_in [*6];
    endsequence
    rst_quiet_a: assert property (disable iff (1'h0) rst_in |=> !tdo_oe_out
        && !int_scan_sel_out && !memory_selftest_instr_out && hrdata_out == 32'h0
        && pad_oe_out == core_oe_in && pad_dout_out == core_dout_in)
        else $error("tap outputs not idle after reset");
    tdo_edge_a: assert property ($changed(tdo_out) |-> !$past(tck_in, 2))
        else $error("tdo moved away from a tck fall");
    oe_edge_a: assert property ($changed(tdo_oe_out) |-> !$past(tck_in, 2))
        else $error("tdo enable moved away from a tck fall");
    ir_edge_a: assert property ($changed(int_scan_sel_out) ||
        $changed(memory_selftest_instr_out) |-> $past(tck_in, 2) == 1'h0)
        else $error("instruction changed away from a tck fall");
    bus_freeze_a: assert property (bus_busy |=> $stable(tdo_oe_out) && $stable(tdo_out))
        else $error("test port moved during bus cycles");
    sel_excl_a: assert property (!(int_scan_sel_out && memory_selftest_instr_out))
        else $error("both internal paths selected");
    id_read_a: assert property (id_req |=> hrdata_out ==
        {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT})
        else $error("identification read wrong");
    trst_a: assert property (!trst_n_in [*8] |=> !tdo_oe_out && !int_scan_sel_out)
        else $error("test reset did not idle the port");
endmodule // boundary_scan_tap_chk

bind boundary_scan_tap boundary_scan_tap_chk chk (.clk_in, .rst_in, .tck_in, .trst_n_in,
    .bus_active_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hready_in, .core_dout_in,
    .core_oe_in, .tdo_out, .tdo_oe_out, .pad_dout_out, .pad_oe_out, .int_scan_sel_out,
    .memory_selftest_instr_out, .hrdata_out);

// File: jtag_tester.sv
/* board tester model: drives tck, tms, tdi and test reset, reads tdo.
   assumes clk_in is the 40 MHz bench clock; tck period 200 ns. */
`timescale 1ns/1ps
module jtag_tester (
    input wire logic clk_in,
    input wire logic tdo_in,
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    output logic trst_n_out
);
    initial begin
        tck_out = 1'h0;
        tms_out = 1'h1;
        tdi_out = 1'h0;
        trst_n_out = 1'h1;
    end
    // one tck period, tdo taken just before the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_out <= tms;
        tdi_out <= tdi;
        repeat (4) @(posedge clk_in);
        tdo = tdo_in;
        tck_out <= 1'h1;
        repeat (4) @(posedge clk_in);
        tck_out <= 1'h0;
    endtask
    // from idle through capture, n shifts, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [43:0] din,
        output logic [43:0] dout);
        logic b;
        dout = 44'h0;
        step(1'h1, 1'h0, b);
        if (ir) step(1'h1, 1'h0, b);
        step(1'h0, 1'h0, b);
        step(1'h0, 1'h0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'h1, ~din[n - 1], b);
        step(1'h0, din[n - 1], b);
        // let the last tck fall pass the synchroniser before anyone looks
        repeat (4) @(posedge clk_in);
    endtask
    task automatic pulse_trst();
        trst_n_out <= 1'h0;
        repeat (10) @(posedge clk_in);
        trst_n_out <= 1'h1;
        repeat (6) @(posedge clk_in);
    endtask
endmodule // jtag_tester

// File: tb.sv
/* self-checking bench of the test access port over ahb and jtag.
   assumes jtag_tester and the bound checker are compiled first. */
`timescale 1ns/1ps
module tb;
    import boundary_scan_tap_pkg::*;
    localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED_BIT};
    localparam logic [43:0] PRE = 44'h9A5C3E1F06B;
    logic clk_in, rst_in, tck, tms, tdi, trst_n, tdo_out, tdo_oe_out, bus_active_in;
    logic [NPIN-1:0] core_dout_in, core_oe_in, pad_in, pad_dout_out, pad_oe_out;
    logic int_sel, mem_sel, hsel, hwrite, hreadyout_out, hresp_out;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata_out, v;
    logic [43:0] d;
    logic [4:0] codes [7] = '{INSTR_HIGHZ, INSTR_CLAMP, INSTR_BYPASS, 5'h03, 5'h11,
        INSTR_INT_SCAN, INSTR_MEM_SELFTEST};
    int bad_count = 0;
    int check_count = 0;
    boundary_scan_tap dut (.clk_in, .rst_in, .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .trst_n_in(trst_n), .tdo_out, .tdo_oe_out, .bus_active_in, .core_dout_in,
        .core_oe_in, .pad_in, .pad_dout_out, .pad_oe_out, .int_scan_tdo_in(1'h1),
        .mem_selftest_tdo_in(1'h0), .int_scan_sel_out(int_sel),
        .memory_selftest_instr_out(mem_sel), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hreadyout_out), .hreadyout_out, .hresp_out, .hrdata_out);
    jtag_tester tst (.clk_in, .tdo_in(tdo_out), .tck_out(tck), .tms_out(tms),
        .tdi_out(tdi), .trst_n_out(trst_n));
    task automatic chk(input logic [43:0] seen, input logic [43:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] stat(input tap_state_t s, input logic [4:0] ir);
        return {19'h0, ir, 3'h0, s == TLR, s};
    endfunction
    function automatic logic [43:0] capt(input logic [NPIN-1:0] p, input logic [NPIN-1:0] o);
        for (int i = 0; i < NPIN; i++) begin
            capt[2 * i] = p[i];
            capt[2 * i + 1] = o[i];
        end
    endfunction
    function automatic logic [NPIN-1:0] pick(input logic [43:0] c, input int k);
        for (int i = 0; i < NPIN; i++) begin
            pick[i] = c[2 * i + k];
        end
    endfunction
    // single ahb-lite transfer, read data kept in v
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        htrans <= HTRANS_NONSEQ;
        haddr <= 32'(a);
        hwrite <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_in); while (hreadyout_out !== 1'h1);
        v = hrdata_out;
        chk(hresp_out, 1'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'h0, a, 32'h0);
        chk(v, e);
    endtask
    initial begin
        clk_in = 1'h0;
        forever #12.5 clk_in = ~clk_in;
    end
    initial begin
        #400000;
        bad_count++;
        end_sim();
    end
    initial begin
        rst_in = 1'h1;
        bus_active_in = 1'h0;
        hsel = 1'h0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        core_dout_in = 22'h15A5A5;
        core_oe_in = 22'h0F0F0F;
        pad_in = 22'h2C3C3C;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'h0;
        @(posedge clk_in);
        rd(OFS_STATUS, stat(TLR, INSTR_IDCODE));
        rd(OFS_IDCODE, ID_WORD);
        rd(8'h10, 32'h0);
        chk(pad_oe_out, core_oe_in);
        ahb(1'h1, OFS_CTRL, 32'h0);
        rd(OFS_CTRL, 32'h0);
        tst.step(1'h0, 1'h0, d[0]);
        rd(OFS_STATUS, stat(TLR, INSTR_IDCODE));
        ahb(1'h1, OFS_CTRL, 32'h1);
        bus_active_in <= 1'h1;
        tst.step(1'h0, 1'h0, d[0]);
        rd(OFS_STATUS, stat(TLR, INSTR_IDCODE));
        bus_active_in <= 1'h0;
        tst.step(1'h0, 1'h0, d[0]);
        rd(OFS_STATUS, stat(RTI, INSTR_IDCODE));
        tst.scan(1'h0, 32, 44'h0, d);
        chk(d[31:0], ID_WORD);
        foreach (codes[i]) begin
            tst.scan(1'h1, 5, 44'(codes[i]), d);
            chk(d[4:0], IR_CAPTURE_VAL);
            rd(OFS_STATUS, stat(RTI, codes[i]));
            chk({int_sel, mem_sel}, {codes[i] == INSTR_INT_SCAN, codes[i] == INSTR_MEM_SELFTEST});
            if (i == 0) chk(pad_oe_out, 22'h0);
            if (i < 5) begin
                tst.scan(1'h0, 2, 44'h3, d);
                chk(d[1:0], 2'h2);
            end else begin
                tst.scan(1'h0, 2, 44'h0, d);
                chk(d[1:0], (codes[i] == INSTR_INT_SCAN) ? 2'h3 : 2'h0);
            end
        end
        tst.scan(1'h1, 5, 44'(INSTR_SAMPLE), d);
        tst.scan(1'h0, 44, PRE, d);
        chk(d, capt(pad_in, core_oe_in));
        chk(pad_dout_out, core_dout_in);
        tst.scan(1'h1, 5, 44'(INSTR_EXTEST), d);
        chk({pad_oe_out, pad_dout_out}, {pick(PRE, 1), pick(PRE, 0)});
        pad_in <= ~pad_in;
        tst.scan(1'h0, 44, PRE, d);
        chk(d, capt(pad_in, pick(PRE, 1)));
        tst.scan(1'h1, 5, 44'(INSTR_CLAMP), d);
        chk({pad_oe_out, pad_dout_out}, {pick(PRE, 1), pick(PRE, 0)});
        tst.pulse_trst();
        rd(OFS_STATUS, stat(TLR, INSTR_IDCODE));
        chk({tdo_oe_out, pad_oe_out}, {1'h0, core_oe_in});
        end_sim();
    end
endmodule // tb
